/* common/psfhs_map.svh */
// offsets, field positions, reset values and timing counts of the psu fault sequencer
// assumes a 25 MHz core clock and a 32-bit classic wishbone slave
`ifndef PSFHS_MAP_SVH
`define PSFHS_MAP_SVH
`define PSFHS_CLK_MHZ 25
// register byte offsets
`define PSFHS_ADR_CTRL 8'h00
`define PSFHS_ADR_TIMA 8'h04
`define PSFHS_ADR_TIMB 8'h08
`define PSFHS_ADR_STAT 8'h0c
// ctrl fields
`define PSFHS_C_AUTO 0
`define PSFHS_C_SRC_LO 2
`define PSFHS_C_SRC_HI 3
`define PSFHS_C_ACSW 4
`define PSFHS_C_SGPU 5
`define PSFHS_C_SGINV 6
`define PSFHS_C_LGPU 7
`define PSFHS_C_LGINV 8
`define PSFHS_C_CLR 9
// timing register fields, all in milliseconds
`define PSFHS_TA_ON_LO 0
`define PSFHS_TA_ON_HI 9
`define PSFHS_TA_OFF_LO 10
`define PSFHS_TA_OFF_HI 15
`define PSFHS_TA_REQ_LO 16
`define PSFHS_TA_REQ_HI 23
`define PSFHS_TB_OCP_LO 0
`define PSFHS_TB_OCP_HI 7
// reset values: on 100 ms, off 2 ms, request filter 80 ms, overcurrent 16 ms
`define PSFHS_CTRL_RST 32'h0000_0000
`define PSFHS_TIMA_RST 32'h0050_0864
`define PSFHS_TIMB_RST 32'h0000_0010
// filter and sequencing times
`define PSFHS_OV_DB_NS 16000
`define PSFHS_OV_DB_CYC ((`PSFHS_OV_DB_NS * `PSFHS_CLK_MHZ) / 1000)
`define PSFHS_UV_DB_US 450
`define PSFHS_UV_DB_CYC (`PSFHS_UV_DB_US * `PSFHS_CLK_MHZ)
`define PSFHS_MS_US 1000
`define PSFHS_MS_CYC (`PSFHS_MS_US * `PSFHS_CLK_MHZ)
`define PSFHS_RESTART_MS 1000
`endif

/* common/psfhs_pkg.sv */
// types shared by the psu fault sequencer files
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package psfhs_pkg;
  typedef enum {st_off, st_start, st_run, st_lowline, st_offdly, st_latched, st_restart} psfhs_state_type;
  typedef enum {fate_off, fate_latch, fate_restart} psfhs_fate_type;
  typedef enum logic [1:0] {src_onboard, src_soft, src_link} psfhs_src_type;
endpackage
`default_nettype wire

/* verilog/psfhs_debounce.sv */
// two-flop synchroniser and level filter for one fault input
// assumes tick_i paces the count and limit_i holds the period in ticks
`default_nettype none
module psfhs_debounce (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        raw_i,
  input  wire logic        tick_i,
  input  wire logic [15:0] limit_i,
  output logic             level_o
);
  logic [1:0]  sync_reg;
  logic [15:0] cnt_reg;

  // synchroniser, first stage read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) sync_reg <= 2'h0;
    else if (ce_i) sync_reg <= {sync_reg[0], raw_i};
  end

  // a new level passes only after it stood for the whole period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
      cnt_reg <= 16'h0000;
    end else if (ce_i) begin
      if (sync_reg[1] == level_o) cnt_reg <= 16'h0000;
      else if (tick_i) begin
        if (cnt_reg + 16'h0001 >= limit_i) begin
          level_o <= sync_reg[1];
          cnt_reg <= 16'h0000;
        end else cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/psfhs_sequencer.sv */
// fault and housekeeping sequencer for a supply secondary controller
// assumes raw comparator pins are asynchronous and software uses classic wishbone
`include "psfhs_map.svh"
`default_nettype none
// What this block does
// - undervoltage: delayed enable drop, latch or restart
// - undervoltage drops supply good at once
// - overvoltage latches, crowbars, kills enable, good
// - overvoltage latch clears by request, reset, command
// - qualified overcurrent shuts down, latched or restarting
// - overcurrent warns first; timeout is configurable
// - overtemperature warns, shuts down, latched or restarting
// - blank undervoltage at power-up and low line
// - overload blanks only for ride-through time
// - line status from sense, software or link
// - supply good drops early on line loss
// - status pins: pull direction and polarity selectable
// - line good only with adequate bulk voltage
// - supply good held false for on delay
// - request low or non-overvoltage fault: good false, delayed enable
// - debounce all inputs with documented periods
// - signal start only with adequate line
// - drop line status early on brownout
// - line recovery starts a full power-up
// - reset clears latches, allows clean start
// - auto-restart retries about once a second
module psfhs_sequencer #(
  parameter int MS_CYC    = `PSFHS_MS_CYC,
  parameter int UV_DB_CYC = `PSFHS_UV_DB_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        undervolt_detect_i,
  input  wire logic        over_volt_protect_i,
  input  wire logic        over_current_i,
  input  wire logic        over_temp_i,
  input  wire logic        onoff_request_i,
  input  wire logic        ac_sense_i,
  input  wire logic        line_good_link_i,
  output logic             power_enable_o,
  output logic             crowbar_drive_o,
  output logic             supply_good_o,
  output logic             supply_good_oe_n_o,
  output logic             line_good_o,
  output logic             line_good_oe_n_o
);
  logic [31:0] ctrl_reg;
  logic [31:0] tima_reg;
  logic [31:0] timb_reg;
  logic        wr_en;
  logic        clr_cmd;
  logic        uv_f, ov_f, ocp_f, otp_f, on_f, acs_f, link_f;
  logic        on_prev_reg;
  logic [15:0] ms_cnt_reg;
  logic        ms_tick;
  logic [9:0]  cnt_reg;
  logic [7:0]  ocp_ms_reg;
  logic        ocp_trip, uv_trip, blank_w, line_good;
  logic        latch_reg, crow_reg, pe_reg, sg_reg, lg_reg;
  logic        set_latch, clr_latch, offdly_done;
  psfhs_pkg::psfhs_state_type state_reg, state_next;
  psfhs_pkg::psfhs_fate_type  fate_reg, fate_next;

  // byte-lane merge used by every writable register
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  // open-drain drive: only the active level is driven, the other is released
  function automatic logic od_drive_n(input logic val, input logic pull_up, input logic inv);
    return ((val ^ inv) == pull_up) ? 1'b0 : 1'b1;
  endfunction

  // bus slave: ack one cycle after the request, write commits on the ack edge
  assign wr_en   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & ce_i;
  assign clr_cmd = wr_en & (wb_adr_i == `PSFHS_ADR_CTRL) & wb_sel_i[1] & wb_dat_i[`PSFHS_C_CLR];

  always_ff @(posedge clk_i) begin
    if (rst_i) wb_ack_o <= 1'b0;
    else if (ce_i) wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end

  // read mux, unmapped offsets answer with zero
  always_ff @(posedge clk_i) begin
    if (rst_i) wb_dat_o <= 32'h0000_0000;
    else if (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      unique case (wb_adr_i)
        `PSFHS_ADR_CTRL: wb_dat_o <= {22'h0, 1'b0, ctrl_reg[8:0]}; // clear bit reads zero
        `PSFHS_ADR_TIMA: wb_dat_o <= {8'h00, tima_reg[23:0]};
        `PSFHS_ADR_TIMB: wb_dat_o <= {24'h0, timb_reg[7:0]};
        `PSFHS_ADR_STAT: wb_dat_o <= {16'h0, 1'b0, 3'(state_reg), crow_reg, latch_reg, pe_reg, sg_reg,
                                      lg_reg, line_good, on_f, otp_f, ocp_f, ov_f, uv_f, blank_w};
        default:         wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `PSFHS_CTRL_RST;
      tima_reg <= `PSFHS_TIMA_RST;
      timb_reg <= `PSFHS_TIMB_RST;
    end else if (wr_en) begin
      if (wb_adr_i == `PSFHS_ADR_CTRL) ctrl_reg <= lane_merge(ctrl_reg, wb_dat_i, wb_sel_i);
      if (wb_adr_i == `PSFHS_ADR_TIMA) tima_reg <= lane_merge(tima_reg, wb_dat_i, wb_sel_i);
      if (wb_adr_i == `PSFHS_ADR_TIMB) timb_reg <= lane_merge(timb_reg, wb_dat_i, wb_sel_i);
    end
  end

  // millisecond time base shared by every slow timer
  always_ff @(posedge clk_i) begin
    if (rst_i) ms_cnt_reg <= 16'h0000;
    else if (ce_i) ms_cnt_reg <= ms_tick ? 16'h0000 : ms_cnt_reg + 16'h0001;
  end
  assign ms_tick = (ms_cnt_reg == 16'(MS_CYC - 1));

  // input filters; fast faults count cycles, the request counts milliseconds
  psfhs_debounce u_db_ov (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .raw_i(over_volt_protect_i),
    .tick_i(1'b1), .limit_i(16'(`PSFHS_OV_DB_CYC)), .level_o(ov_f));
  psfhs_debounce u_db_uv (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .raw_i(undervolt_detect_i),
    .tick_i(1'b1), .limit_i(16'(UV_DB_CYC)), .level_o(uv_f));
  psfhs_debounce u_db_on (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .raw_i(onoff_request_i),
    .tick_i(ms_tick), .limit_i({8'h00, tima_reg[`PSFHS_TA_REQ_HI:`PSFHS_TA_REQ_LO]}), .level_o(on_f));
  psfhs_debounce u_db_oc (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .raw_i(over_current_i),
    .tick_i(1'b1), .limit_i(16'(`PSFHS_OV_DB_CYC)), .level_o(ocp_f));
  psfhs_debounce u_db_ot (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .raw_i(over_temp_i),
    .tick_i(1'b1), .limit_i(16'(`PSFHS_OV_DB_CYC)), .level_o(otp_f));
  psfhs_debounce u_db_ac (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .raw_i(ac_sense_i),
    .tick_i(1'b1), .limit_i(16'(`PSFHS_OV_DB_CYC)), .level_o(acs_f));
  psfhs_debounce u_db_lk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .raw_i(line_good_link_i),
    .tick_i(1'b1), .limit_i(16'(`PSFHS_OV_DB_CYC)), .level_o(link_f));

  // line status source; the unused code falls back to the on-board sense
  always_comb begin
    unique case (psfhs_pkg::psfhs_src_type'(ctrl_reg[`PSFHS_C_SRC_HI:`PSFHS_C_SRC_LO]))
      psfhs_pkg::src_soft: line_good = ctrl_reg[`PSFHS_C_ACSW];
      psfhs_pkg::src_link: line_good = link_f;
      default:             line_good = acs_f;
    endcase
  end

  // overcurrent qualification; during ride-through the output is in current limit
  always_ff @(posedge clk_i) begin
    if (rst_i) ocp_ms_reg <= 8'h00;
    else if (ce_i) begin
      if (!ocp_f) ocp_ms_reg <= 8'h00;
      else if (ms_tick && !ocp_trip) ocp_ms_reg <= ocp_ms_reg + 8'h01;
    end
  end
  assign ocp_trip = ocp_f & (ocp_ms_reg >= timb_reg[`PSFHS_TB_OCP_HI:`PSFHS_TB_OCP_LO]);

  // blanking: power-up, low line, and overload only until ride-through ends
  assign blank_w = (state_reg == psfhs_pkg::st_start) | ~line_good | (ocp_f & ~ocp_trip);
  assign uv_trip = uv_f & ~blank_w & (state_reg == psfhs_pkg::st_run);

  // per-state millisecond counter, restarted on every state change
  always_ff @(posedge clk_i) begin
    if (rst_i) cnt_reg <= 10'h000;
    else if (ce_i) begin
      if (state_next != state_reg) cnt_reg <= 10'h000;
      else if (ms_tick && cnt_reg != 10'h3ff) cnt_reg <= cnt_reg + 10'h001;
    end
  end

  // off delay elapsed; read from the counter only, so the latch set cannot loop through state_next
  assign offdly_done = (cnt_reg >= {4'h0, tima_reg[`PSFHS_TA_OFF_HI:`PSFHS_TA_OFF_LO]});

  // sequencing state machine
  always_comb begin
    state_next = state_reg;
    fate_next  = fate_reg;
    unique case (state_reg)
      psfhs_pkg::st_off: begin
        if (on_f && line_good) state_next = psfhs_pkg::st_start;
      end
      psfhs_pkg::st_start: begin
        if (!on_f) begin
          state_next = psfhs_pkg::st_offdly;
          fate_next  = psfhs_pkg::fate_off;
        end else if (cnt_reg >= tima_reg[`PSFHS_TA_ON_HI:`PSFHS_TA_ON_LO]) state_next = psfhs_pkg::st_run;
      end
      psfhs_pkg::st_run: begin
        if (ocp_trip || otp_f || uv_trip) begin
          state_next = psfhs_pkg::st_offdly;
          fate_next  = ctrl_reg[`PSFHS_C_AUTO] ? psfhs_pkg::fate_restart : psfhs_pkg::fate_latch;
        end else if (!on_f) begin
          state_next = psfhs_pkg::st_offdly;
          fate_next  = psfhs_pkg::fate_off;
        end else if (!line_good) state_next = psfhs_pkg::st_lowline;
      end
      psfhs_pkg::st_lowline: begin
        if (!on_f) begin
          state_next = psfhs_pkg::st_offdly;
          fate_next  = psfhs_pkg::fate_off;
        end else if (line_good) state_next = psfhs_pkg::st_start;
      end
      psfhs_pkg::st_offdly: begin
        if (offdly_done) begin
          unique case (fate_reg)
            psfhs_pkg::fate_latch:   state_next = psfhs_pkg::st_latched;
            psfhs_pkg::fate_restart: state_next = psfhs_pkg::st_restart;
            psfhs_pkg::fate_off:     state_next = psfhs_pkg::st_off;
          endcase
        end
      end
      psfhs_pkg::st_latched: begin
        if (!latch_reg && !set_latch) state_next = psfhs_pkg::st_off;
      end
      psfhs_pkg::st_restart: begin
        if (cnt_reg >= 10'(`PSFHS_RESTART_MS)) state_next = psfhs_pkg::st_off;
      end
    endcase
    if (set_latch || latch_reg) state_next = psfhs_pkg::st_latched;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= psfhs_pkg::st_off;
      fate_reg  <= psfhs_pkg::fate_off;
    end else if (ce_i) begin
      state_reg <= state_next;
      fate_reg  <= fate_next;
    end
  end

  // protection latch shared by overvoltage and latched shutdowns; a set beats a clear
  assign set_latch = ov_f | ((state_reg == psfhs_pkg::st_offdly) & offdly_done & (fate_reg == psfhs_pkg::fate_latch));
  assign clr_latch = clr_cmd | (on_prev_reg & ~on_f);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_reg   <= 1'b0;
      crow_reg    <= 1'b0;
      on_prev_reg <= 1'b0;
    end else if (ce_i) begin
      on_prev_reg <= on_f;
      if (set_latch) latch_reg <= 1'b1;
      else if (clr_latch) latch_reg <= 1'b0;
      if (ov_f) crow_reg <= 1'b1;
      else if (clr_latch) crow_reg <= 1'b0;
    end
  end

  // outputs; supply good falls the cycle a fault is seen, before the enable except on overvoltage, where both fall together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pe_reg <= 1'b0;
      sg_reg <= 1'b0;
      lg_reg <= 1'b0;
    end else if (ce_i) begin
      pe_reg <= (state_next == psfhs_pkg::st_start) | (state_next == psfhs_pkg::st_run) |
                (state_next == psfhs_pkg::st_lowline) | (state_next == psfhs_pkg::st_offdly);
      sg_reg <= (state_next == psfhs_pkg::st_run) & line_good & ~ov_f & ~otp_f & ~ocp_f & ~uv_trip;
      lg_reg <= line_good;
    end
  end

  assign power_enable_o     = pe_reg;
  assign crowbar_drive_o    = crow_reg;
  assign supply_good_o      = ctrl_reg[`PSFHS_C_SGPU];
  assign supply_good_oe_n_o = od_drive_n(sg_reg, ctrl_reg[`PSFHS_C_SGPU], ctrl_reg[`PSFHS_C_SGINV]);
  assign line_good_o        = ctrl_reg[`PSFHS_C_LGPU];
  assign line_good_oe_n_o   = od_drive_n(lg_reg, ctrl_reg[`PSFHS_C_LGPU], ctrl_reg[`PSFHS_C_LGINV]);

  // checks
  a_ov_latch_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && ov_f) |=> (latch_reg && crow_reg && !pe_reg && !sg_reg))
    else $error("overvoltage did not latch off");
  a_latch_holds_off: assert property (@(posedge clk_i) disable iff (rst_i)
    latch_reg |-> (!pe_reg && !sg_reg))
    else $error("output on while latched");
  a_uv_good_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && uv_trip) |=> (!sg_reg && pe_reg))
    else $error("undervoltage did not drop good first");
  a_start_good_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == psfhs_pkg::st_start) |-> !sg_reg)
    else $error("good high during on delay");
  a_offdly_order: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == psfhs_pkg::st_offdly) |-> (!sg_reg && pe_reg))
    else $error("off delay order broken");
  a_clear_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && clr_cmd && !set_latch) |=> !latch_reg)
    else $error("clear command ignored");
  a_blank_uv: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && uv_f && on_f && !latch_reg && !set_latch &&
     (state_reg == psfhs_pkg::st_start || state_reg == psfhs_pkg::st_lowline)) |=> (state_reg != psfhs_pkg::st_offdly))
    else $error("undervoltage not blanked");
  a_line_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !line_good) |=> (!lg_reg && !sg_reg))
    else $error("line loss not flagged");
  a_ocp_warn: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && ocp_trip && state_reg == psfhs_pkg::st_run) |=> (!sg_reg && pe_reg))
    else $error("overcurrent without warning");
endmodule
`default_nettype wire

/* test/psfhs_host_model.sv */
// host system side of the psu fault sequencer: request, line sense and status pin readers
// assumes the bench changes the wishes by non-blocking assignment just after a clock edge
`default_nettype none
module psfhs_host_model (
  input  wire logic clk_i,
  input  wire logic want_on_i,
  input  wire logic want_line_i,
  input  wire logic want_link_i,
  input  wire logic sg_val_i,
  input  wire logic sg_oe_n_i,
  input  wire logic sg_inv_i,
  input  wire logic lg_val_i,
  input  wire logic lg_oe_n_i,
  input  wire logic lg_inv_i,
  output logic      onoff_request_o,
  output logic      ac_sense_o,
  output logic      line_good_link_o,
  output logic      sg_status_o,
  output logic      lg_status_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sg_pin;
  logic lg_pin;
  // the host's wishes reach the pins as levels, so they already move on edges only
  assign onoff_request_o  = want_on_i;
  assign ac_sense_o       = want_line_i;
  assign line_good_link_o = want_link_i;
  // a released pin goes to the opposite pull level, never to the last driven value
  assign sg_pin = sg_oe_n_i ? ~sg_val_i : sg_val_i;
  assign lg_pin = lg_oe_n_i ? ~lg_val_i : lg_val_i;
  // the host undoes the configured polarity to get the logical status
  assign sg_status_o = sg_pin ^ sg_inv_i;
  assign lg_status_o = lg_pin ^ lg_inv_i;
endmodule
`default_nettype wire

/* test/psfhs_sequencer_bench.sv */
// self-checking bench for the psu fault sequencer
// assumes short ms ticks (25 cycles) and a host model that resolves the status pins
`include "psfhs_map.svh"
`default_nettype none
module psfhs_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] exp; logic [31:0] mask;} psfhs_note_type;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic uv, ov, oc, ot, want_on, want_line, want_link, sg_inv, pu, iv;
  logic req, acs, lnk, sg_st, lg_st, pe, cb, sg_v, sg_oe_n, lg_v, lg_oe_n;
  int miscompares, checks, seed;
  psfhs_note_type note_q[$];
  psfhs_note_type cur;
  // clock at 25 mhz
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  psfhs_sequencer #(.MS_CYC(25), .UV_DB_CYC(20)) i_psfhs_sequencer (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .undervolt_detect_i(uv), .over_volt_protect_i(ov), .over_current_i(oc), .over_temp_i(ot),
    .onoff_request_i(req), .ac_sense_i(acs), .line_good_link_i(lnk), .power_enable_o(pe),
    .crowbar_drive_o(cb), .supply_good_o(sg_v), .supply_good_oe_n_o(sg_oe_n), .line_good_o(lg_v),
    .line_good_oe_n_o(lg_oe_n));
  psfhs_host_model i_psfhs_host_model (
    .clk_i(clk_i), .want_on_i(want_on), .want_line_i(want_line), .want_link_i(want_link),
    .sg_val_i(sg_v), .sg_oe_n_i(sg_oe_n), .sg_inv_i(sg_inv), .lg_val_i(lg_v), .lg_oe_n_i(lg_oe_n),
    .lg_inv_i(sg_inv), .onoff_request_o(req), .ac_sense_o(acs), .line_good_link_o(lnk),
    .sg_status_o(sg_st), .lg_status_o(lg_st));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one classic cycle; reads leave their expectation in the note queue
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel,
                    input logic [31:0] exp, input logic [31:0] mask);
    int n;
    n = 0;
    @(posedge clk_i);
    if (!we) note_q.push_back('{exp & mask, mask});
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] mask);
    wb(1'b0, adr, 32'h0, 4'hf, exp, mask);
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb(1'b1, adr, dat, 4'hf, 32'h0, 32'h0);
  endtask
  task automatic stat(input logic [2:0] st, input logic c, input logic l, input logic p, input logic s);
    rd(`PSFHS_ADR_STAT, {17'h0, st, c, l, p, s, 8'h0}, 32'h0000_7f00);
  endtask
  // read answers are matched against the oldest note, at the edge that samples ack
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && note_q.size() > 0) begin
      cur = note_q.pop_front();
      chk(wb_dat_o & cur.mask, cur.exp);
    end
  end
  // watchdog sized well above the slowest path, the one second restart wait
  initial begin
    #3000000;
    miscompares++;
    complete_run();
  end
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, uv, ov, oc, ot, want_on, sg_inv} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {ce_i, rst_i, want_line, want_link} = 4'hf;
    {miscompares, checks, pu, iv} = '0;
    seed = 31485;
    wait_cyc(8);
    rst_i <= 1'b0;
    chk(32'({pe, cb, sg_v, sg_oe_n, lg_v, lg_oe_n}), 32'h0);
    rd(`PSFHS_ADR_CTRL, `PSFHS_CTRL_RST, 32'hffff_ffff);
    rd(`PSFHS_ADR_TIMA, `PSFHS_TIMA_RST, 32'hffff_ffff);
    rd(`PSFHS_ADR_TIMB, `PSFHS_TIMB_RST, 32'hffff_ffff);
    stat(3'd0, 1'b0, 1'b0, 1'b0, 1'b0);
    wb(1'b1, 8'h10, $random(seed), 4'($random(seed)), 32'h0, 32'h0);
    rd(8'h10, 32'h0, 32'hffff_ffff);
    wr(`PSFHS_ADR_TIMA, 32'h0002_080a);
    wb(1'b1, `PSFHS_ADR_TIMB, 32'hffff_ff02, 4'h1, 32'h0, 32'h0);
    rd(`PSFHS_ADR_TIMA, 32'h0002_080a, 32'hffff_ffff);
    rd(`PSFHS_ADR_TIMB, 32'h0000_0002, 32'hffff_ffff);
    $display("test registers done");
    want_on <= 1'b1;
    wait_cyc(150);
    // the line sense filter is still settling, so the request alone must not start
    stat(3'd0, 1'b0, 1'b0, 1'b0, 1'b0);
    wait_cyc(300);
    stat(3'd1, 1'b0, 1'b0, 1'b1, 1'b0);
    wait_cyc(350);
    stat(3'd2, 1'b0, 1'b0, 1'b1, 1'b1);
    $display("test power up done");
    want_line <= 1'b0;
    wait_cyc(450);
    stat(3'd3, 1'b0, 1'b0, 1'b1, 1'b0);
    chk(32'(lg_st), 32'h0);
    uv <= 1'b1;
    wait_cyc(100);
    stat(3'd3, 1'b0, 1'b0, 1'b1, 1'b0);
    uv <= 1'b0;
    wait_cyc(50);
    want_line <= 1'b1;
    wait_cyc(450);
    stat(3'd1, 1'b0, 1'b0, 1'b1, 1'b0);
    wait_cyc(300);
    stat(3'd2, 1'b0, 1'b0, 1'b1, 1'b1);
    $display("test line loss done");
    // overcurrent then overtemperature, both into the shared latch
    for (int k = 0; k < 2; k++) begin
      if (k == 0) oc <= 1'b1;
      else ot <= 1'b1;
      wait_cyc(k ? 415 : 700);
      if (k) stat(3'd4, 1'b0, 1'b0, 1'b1, 1'b0);
      if (k) wait_cyc(285);
      stat(3'd5, 1'b0, 1'b1, 1'b0, 1'b0);
      oc <= 1'b0;
      ot <= 1'b0;
      wait_cyc(450);
      stat(3'd5, 1'b0, 1'b1, 1'b0, 1'b0);
      wr(`PSFHS_ADR_CTRL, 32'h0000_0200);
      wait_cyc(450);
      stat(3'd2, 1'b0, 1'b0, 1'b1, 1'b1);
    end
    $display("test current and heat done");
    ov <= 1'b1;
    wait_cyc(450);
    chk(32'({pe, cb}), 32'h1);
    stat(3'd5, 1'b1, 1'b1, 1'b0, 1'b0);
    ov <= 1'b0;
    wait_cyc(450);
    stat(3'd5, 1'b1, 1'b1, 1'b0, 1'b0);
    want_on <= 1'b0;
    wait_cyc(150);
    stat(3'd0, 1'b0, 1'b0, 1'b0, 1'b0);
    want_on <= 1'b1;
    wait_cyc(500);
    stat(3'd2, 1'b0, 1'b0, 1'b1, 1'b1);
    $display("test overvoltage done");
    wr(`PSFHS_ADR_CTRL, 32'h0000_0001);
    uv <= 1'b1;
    wait_cyc(30);
    stat(3'd4, 1'b0, 1'b0, 1'b1, 1'b0);
    wait_cyc(150);
    stat(3'd6, 1'b0, 1'b0, 1'b0, 1'b0);
    uv <= 1'b0;
    wait_cyc(24700);
    stat(3'd6, 1'b0, 1'b0, 1'b0, 1'b0);
    wait_cyc(450);
    rd(`PSFHS_ADR_STAT, 32'h0000_0200, 32'h0000_0200);
    wait_cyc(300);
    $display("test auto restart done");
    // every pull direction and polarity on both status pins while running
    for (int k = 0; k < 4; k++) begin
      pu = k[0];
      iv = k[1];
      wr(`PSFHS_ADR_CTRL, {23'h0, iv, pu, iv, pu, 5'h0});
      sg_inv <= iv;
      wait_cyc(3);
      chk(32'({sg_v, sg_oe_n, lg_v, lg_oe_n, sg_st, lg_st}), {26'h0, pu, ~(pu ^ iv), pu, ~(pu ^ iv), 2'b11});
    end
    sg_inv <= 1'b0;
    $display("test pin modes done");
    wr(`PSFHS_ADR_CTRL, 32'h0000_0004);
    wait_cyc(500);
    stat(3'd3, 1'b0, 1'b0, 1'b1, 1'b0);
    wr(`PSFHS_ADR_CTRL, 32'h0000_0014);
    wait_cyc(700);
    rd(`PSFHS_ADR_STAT, 32'h0000_0240, 32'h0000_0240);
    want_link <= 1'b0;
    wr(`PSFHS_ADR_CTRL, 32'h0000_0008);
    wait_cyc(500);
    rd(`PSFHS_ADR_STAT, 32'h0000_0200, 32'h0000_0340);
    want_link <= 1'b1;
    wait_cyc(500);
    rd(`PSFHS_ADR_STAT, 32'h0000_0240, 32'h0000_0240);
    // a low clock enable must freeze the on delay count
    ce_i <= 1'b0;
    wait_cyc(300);
    ce_i <= 1'b1;
    stat(3'd1, 1'b0, 1'b0, 1'b1, 1'b0);
    wait_cyc(300);
    stat(3'd2, 1'b0, 1'b0, 1'b1, 1'b1);
    $display("test line source done");
    wait_cyc(4);
    complete_run();
  end
endmodule
`default_nettype wire
